// file: verilog/pic_pair_cfg.svh
`ifndef PIC_PAIR_CFG_SVH
`define PIC_PAIR_CFG_SVH
// I/O port addresses
`define PIC_MASTER_EVEN 8'h20
`define PIC_MASTER_ODD 8'h21
`define PIC_SLAVE_EVEN 8'ha0
`define PIC_SLAVE_ODD 8'ha1
// Field positions
`define PIC_START_BIT 4
`define PIC_LEVEL_BIT 3
`define PIC_SINGLE_BIT 1
`define PIC_NEED_W4_BIT 0
`define PIC_NEST_BIT 4
`define PIC_AEOI_BIT 1
`define PIC_OP3_BIT 3
`define PIC_POLL_BIT 2
`define PIC_CASC_BIT 2
// Command codes of the end command field
`define PIC_CMD_CLR_ROT 3'h0
`define PIC_CMD_NS_EOI 3'h1
`define PIC_CMD_SP_EOI 3'h3
`define PIC_CMD_SET_ROT 3'h4
`define PIC_CMD_ROT_NS 3'h5
`define PIC_CMD_SET_PRIO 3'h6
`define PIC_CMD_ROT_SP 3'h7
// Two-bit selectors and levels
`define PIC_SMM_OFF 2'h2
`define PIC_SMM_ON 2'h3
`define PIC_CASC_LEVEL 3'h2
`define PIC_RST_LOWEST 3'h7
`define PIC_SPURIOUS 3'h7
`endif

// file: verilog/pic_pair_pkg.sv
`default_nettype none
package pic_pair_pkg;
   // One I/O cycle from the host, all on clk_sys
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } io_req_t;
   // Position in the initialization sequence
   typedef enum logic [3:0] {
      ST_READY = 4'b0001,
      ST_W2 = 4'b0010,
      ST_W3 = 4'b0100,
      ST_W4 = 4'b1000
   } init_state_t;
endpackage
`default_nettype wire

// file: verilog/pic_pair.sv
// What this block does
// RULE1: First init word (bit 4) restarts initialization
// RULE2: Bit 0 of first word requests fourth word
// RULE3: Even write, bit 4 low, is op word
// RULE4: Bit 3 selects edge or level sensing
// RULE5: Software enables level mode before selecting it
// RULE6: Bit 1 selects single or cascade; rest ignored
// RULE7: Second word gives vector base bits 7-3
// RULE8: Master third word bit 2 marks slave
// RULE9: Slave third word bits 2-0 hold identity
// RULE10: Fourth word bit 4 enables special nesting
// RULE11: Fourth word bit 1 selects automatic end
// RULE12: Software writes fixed bits of fourth word
// RULE13: Slave never takes a fourth word
// RULE14: Odd writes after setup load the mask
// RULE15: Op word two decodes end command field
// RULE16: Level field used by set priority
// RULE17: Software writes fixed bits of op words
// RULE18: Op word three bits 6-5 control special mask
// RULE19: Poll command makes next read return level
// RULE20: Op word three bits 1-0 select readback
// RULE21: Even and odd ports per controller decoded
// RULE22: Second acknowledge drives vector, sets in-service
// RULE23: Non-specific end clears highest in-service bit
// RULE24: Fixed priority level 0 first; rotation
// RULE25: Slave request drives master input 2
// RULE26: Odd writes follow the initialization order
// RULE27: Vector is base plus granted level
`timescale 1ns/10ps
`default_nettype none
`include "pic_pair_cfg.svh"

module pic_unit #(
   parameter bit IS_SLAVE = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Host I/O cycle and port selects
   input wire pic_pair_pkg::io_req_t io,
   input wire logic sel_even,
   input wire logic sel_odd,
   // Requests and level mode permission
   input wire logic [7:0] req_in,
   input wire logic level_en,
   // Acknowledge phases
   input wire logic ack_first,
   input wire logic ack_second,
   // Results
   output logic int_out,
   output logic [7:0] vector,
   output logic cascade_hit,
   output logic [7:0] rd_data
);
   pic_pair_pkg::init_state_t state_q;
   logic level_q, single_q, need_w4_q, nest_q, aeoi_q, rot_aeoi_q;
   logic smm_q, rd_isr_q, poll_q, gvalid_q;
   logic [4:0] base_q;
   logic [7:0] casc_q, mask_q, irr_q, isr_q, req_prev_q, irr_d;
   logic [2:0] lowest_q, grant_q, best, isr_lvl;
   logic found, isr_any;
   logic [3:0] best_rank, isr_rank;
   logic wr_even, wr_odd, start, op2, op3, poll_rd, take, level_mode;
   logic [2:0] cmd, lvl, take_lvl;

   // Priority rank of a level: 0 is the highest under the current rotation
   function automatic logic [2:0] rank(input logic [2:0] l,
                                       input logic [2:0] low);
      rank = l - low - 3'h1;
   endfunction

   // Write decode
   assign wr_even = io.wr & sel_even;
   assign wr_odd = io.wr & sel_odd;
   assign start = wr_even & io.wdata[`PIC_START_BIT]; // RULE1
   assign op2 = wr_even & ~io.wdata[`PIC_START_BIT]
              & ~io.wdata[`PIC_OP3_BIT]; // RULE3
   assign op3 = wr_even & ~io.wdata[`PIC_START_BIT]
              & io.wdata[`PIC_OP3_BIT]; // RULE3
   assign cmd = io.wdata[7:5];
   assign lvl = io.wdata[2:0];
   assign poll_rd = io.rd & (sel_even | sel_odd) & poll_q;
   assign level_mode = level_q & level_en; // RULE5
   // Acknowledge or poll read takes the granted level into service
   assign take = (ack_second & gvalid_q) | (poll_rd & found); // RULE19
   assign take_lvl = poll_rd ? best : grant_q;

   // Priority resolution over requests and in-service levels
   always_comb
   begin
      isr_rank = 4'h8;
      isr_lvl = 3'h0;
      best_rank = 4'h8;
      best = 3'h0;
      for (int i = 0; i < 8; i++)
      begin
         if (isr_q[i] && {1'b0, rank(3'(i), lowest_q)} < isr_rank)
         begin
            isr_rank = {1'b0, rank(3'(i), lowest_q)}; // RULE24
            isr_lvl = 3'(i);
         end
      end
      for (int i = 0; i < 8; i++)
      begin
         if (irr_q[i] && !mask_q[i] // RULE14
             && (smm_q ? !isr_q[i] // RULE18
                 : ({1'b0, rank(3'(i), lowest_q)} < isr_rank
                    || (nest_q && 3'(i) == `PIC_CASC_LEVEL
                        && {1'b0, rank(3'(i), lowest_q)} == isr_rank)))
             && {1'b0, rank(3'(i), lowest_q)} < best_rank) // RULE10
         begin
            best_rank = {1'b0, rank(3'(i), lowest_q)}; // RULE24
            best = 3'(i);
         end
      end
   end
   assign found = best_rank != 4'h8;
   assign isr_any = isr_rank != 4'h8;
   assign int_out = found;

   // Initialization sequence
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         state_q <= pic_pair_pkg::ST_READY;
      else if (start)
         state_q <= pic_pair_pkg::ST_W2; // RULE1
      else if (wr_odd)
      begin
         case (state_q)
            pic_pair_pkg::ST_W2: // RULE26
               if (!single_q)
                  state_q <= pic_pair_pkg::ST_W3;
               else if (need_w4_q)
                  state_q <= pic_pair_pkg::ST_W4;
               else
                  state_q <= pic_pair_pkg::ST_READY;
            pic_pair_pkg::ST_W3:
               state_q <= need_w4_q ? pic_pair_pkg::ST_W4
                                    : pic_pair_pkg::ST_READY; // RULE2
            pic_pair_pkg::ST_W4:
               state_q <= pic_pair_pkg::ST_READY;
            default:
               state_q <= pic_pair_pkg::ST_READY;
         endcase
      end
   end

   // Configuration words
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         level_q <= 1'b0;
         single_q <= 1'b0;
         need_w4_q <= 1'b0;
         nest_q <= 1'b0;
         aeoi_q <= 1'b0;
         base_q <= 5'h00;
         casc_q <= 8'h00;
      end
      else if (start)
      begin
         level_q <= io.wdata[`PIC_LEVEL_BIT]; // RULE4
         single_q <= io.wdata[`PIC_SINGLE_BIT]; // RULE6
         need_w4_q <= IS_SLAVE ? 1'b0 : io.wdata[`PIC_NEED_W4_BIT]; // RULE13
         if (!io.wdata[`PIC_NEED_W4_BIT] || IS_SLAVE)
         begin
            nest_q <= 1'b0; // RULE2
            aeoi_q <= 1'b0;
         end
      end
      else if (wr_odd)
      begin
         if (state_q == pic_pair_pkg::ST_W2)
            base_q <= io.wdata[7:3]; // RULE7
         if (state_q == pic_pair_pkg::ST_W3)
            casc_q <= io.wdata; // RULE9
         if (state_q == pic_pair_pkg::ST_W4)
         begin
            nest_q <= io.wdata[`PIC_NEST_BIT]; // RULE10
            aeoi_q <= io.wdata[`PIC_AEOI_BIT]; // RULE11
         end
      end
   end

   // Mask register
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         mask_q <= 8'h00;
      else if (start)
         mask_q <= 8'h00;
      else if (wr_odd && state_q == pic_pair_pkg::ST_READY)
         mask_q <= io.wdata; // RULE14
   end

   // Request register, one slice per input; a new edge wins over a clear
   generate
      for (genvar g = 0; g < 8; g++)
      begin : g_irr
         always_comb
         begin
            if (level_mode)
               irr_d[g] = req_in[g]; // RULE4
            else if (req_in[g] && !req_prev_q[g])
               irr_d[g] = 1'b1;
            else if (start || (take && take_lvl == 3'(g)))
               irr_d[g] = 1'b0; // RULE22
            else
               irr_d[g] = irr_q[g];
         end
      end
   endgenerate

   // Request and edge history registers
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         irr_q <= 8'h00;
         req_prev_q <= 8'h00;
      end
      else
      begin
         irr_q <= irr_d;
         req_prev_q <= req_in;
      end
   end

   // In-service register: end commands clear, a new grant sets
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         isr_q <= 8'h00;
      else if (start)
         isr_q <= 8'h00;
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (op2 && isr_any && isr_lvl == 3'(i)
                && (cmd == `PIC_CMD_NS_EOI || cmd == `PIC_CMD_ROT_NS))
               isr_q[i] <= 1'b0; // RULE23
            if (op2 && lvl == 3'(i)
                && (cmd == `PIC_CMD_SP_EOI || cmd == `PIC_CMD_ROT_SP))
               isr_q[i] <= 1'b0; // RULE15
            if (take && !aeoi_q && take_lvl == 3'(i))
               isr_q[i] <= 1'b1; // RULE11
         end
      end
   end

   // Rotation: lowest priority level and rotate on automatic end
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lowest_q <= `PIC_RST_LOWEST;
         rot_aeoi_q <= 1'b0;
      end
      else if (start)
      begin
         lowest_q <= `PIC_RST_LOWEST; // RULE24
         rot_aeoi_q <= 1'b0;
      end
      else if (op2)
      begin
         case (cmd) // RULE15
            `PIC_CMD_CLR_ROT: rot_aeoi_q <= 1'b0;
            `PIC_CMD_SET_ROT: rot_aeoi_q <= 1'b1;
            `PIC_CMD_ROT_NS: if (isr_any) lowest_q <= isr_lvl;
            `PIC_CMD_SET_PRIO: lowest_q <= lvl; // RULE16
            `PIC_CMD_ROT_SP: lowest_q <= lvl;
            default: lowest_q <= lowest_q;
         endcase
      end
      else if (take && aeoi_q && rot_aeoi_q)
         lowest_q <= take_lvl; // RULE24
   end

   // Special mask, readback select and poll
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         smm_q <= 1'b0;
         rd_isr_q <= 1'b0;
         poll_q <= 1'b0;
      end
      else if (start)
      begin
         smm_q <= 1'b0;
         rd_isr_q <= 1'b0;
         poll_q <= 1'b0;
      end
      else if (op3)
      begin
         if (io.wdata[6:5] == `PIC_SMM_ON)
            smm_q <= 1'b1; // RULE18
         else if (io.wdata[6:5] == `PIC_SMM_OFF)
            smm_q <= 1'b0;
         if (io.wdata[1])
            rd_isr_q <= io.wdata[0]; // RULE20
         poll_q <= io.wdata[`PIC_POLL_BIT]; // RULE19
      end
      else if (poll_rd)
         poll_q <= 1'b0;
   end

   // Level frozen by the first acknowledge
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         grant_q <= 3'h0;
         gvalid_q <= 1'b0;
      end
      else if (ack_first)
      begin
         grant_q <= found ? best : `PIC_SPURIOUS;
         gvalid_q <= found;
      end
      else if (ack_second)
         gvalid_q <= 1'b0;
   end

   // Vector, cascade hand-off and readback
   assign vector = {base_q, grant_q}; // RULE27
   assign cascade_hit = !IS_SLAVE && !single_q && gvalid_q
                      && casc_q[`PIC_CASC_BIT]
                      && grant_q == `PIC_CASC_LEVEL; // RULE8
   assign rd_data = poll_q ? {found, 4'h0, best} // RULE19
                  : sel_odd ? mask_q
                  : rd_isr_q ? isr_q : irr_q; // RULE20

   // Checks on this controller
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   AST_INIT_START: assert property (start |=> // RULE1
      state_q == pic_pair_pkg::ST_W2 && mask_q == 8'h00 && isr_q == 8'h00)
      else $error("init start did not restart sequence");
   AST_SLAVE_NO_W4: assert property (IS_SLAVE |-> // RULE13
      state_q != pic_pair_pkg::ST_W4)
      else $error("slave entered fourth word state");
   AST_MASK_LOAD: assert property ( // RULE14
      wr_odd && !start && state_q == pic_pair_pkg::ST_READY
      |=> mask_q == $past(io.wdata))
      else $error("mask not loaded");
   AST_SP_EOI: assert property ( // RULE15
      op2 && cmd == `PIC_CMD_SP_EOI && !take |=> !isr_q[$past(lvl)])
      else $error("specific end did not clear in-service");
   AST_SET_PRIO: assert property ( // RULE16
      op2 && cmd == `PIC_CMD_SET_PRIO |=> lowest_q == $past(lvl))
      else $error("set priority not applied");
   AST_SMM_ON: assert property ( // RULE18
      op3 && io.wdata[6:5] == `PIC_SMM_ON |=> smm_q ##1 smm_q || op3 || start)
      else $error("special mask not set");
   AST_ACK_ISR: assert property ( // RULE22
      ack_second && gvalid_q && !aeoi_q && !op2 && !start
      |=> isr_q[$past(grant_q)] && !gvalid_q)
      else $error("acknowledge did not set in-service");
   AST_POLL_ONCE: assert property ( // RULE19
      poll_rd && !op3 && !start |=> !poll_q)
      else $error("poll not cleared by read");
   AST_FIXED_TOP: assert property ( // RULE24
      lowest_q == 3'h7 && irr_q[0] && !mask_q[0] && isr_q == 8'h00
      |-> found && best == 3'h0)
      else $error("level 0 not highest under fixed priority");
endmodule // pic_unit

module pic_pair (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Host I/O cycles
   input wire pic_pair_pkg::io_req_t io,
   output logic [7:0] io_rdata,
   // Interrupt request pins, 0-7 master except 2 (unused, slave drives that input), 8-15 slave
   input wire logic [15:0] irq_pin,
   input wire logic level_mode_enable,
   // Interrupt to the CPU and acknowledge cycles
   output logic cpu_int,
   input wire logic ack_pulse,
   output logic [7:0] ack_vector,
   output logic ack_vector_valid
);
   logic [15:0] sync1_q, sync2_q;
   logic m_even, m_odd, s_even, s_odd, phase_q, ack_first, ack_second;
   logic m_int, s_int, m_casc;
   logic [7:0] m_vec, s_vec, m_rd, s_rd;

   // Pin synchronisers
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end
      else
      begin
         sync1_q <= irq_pin;
         sync2_q <= sync1_q;
      end
   end

   // Port decode
   assign m_even = io.addr == `PIC_MASTER_EVEN; // RULE21
   assign m_odd = io.addr == `PIC_MASTER_ODD;
   assign s_even = io.addr == `PIC_SLAVE_EVEN;
   assign s_odd = io.addr == `PIC_SLAVE_ODD;

   // Acknowledge phase: first pulse freezes, second takes the vector
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         phase_q <= 1'b0;
      else if (ack_pulse)
         phase_q <= ~phase_q;
   end
   assign ack_first = ack_pulse & ~phase_q;
   assign ack_second = ack_pulse & phase_q;

   pic_unit #(.IS_SLAVE(1'b0)) u_master (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .io(io),
      .sel_even(m_even),
      .sel_odd(m_odd),
      .req_in({sync2_q[7:3], s_int, sync2_q[1:0]}), // RULE25
      .level_en(level_mode_enable),
      .ack_first(ack_first),
      .ack_second(ack_second),
      .int_out(m_int),
      .vector(m_vec),
      .cascade_hit(m_casc),
      .rd_data(m_rd)
   );

   pic_unit #(.IS_SLAVE(1'b1)) u_slave (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .io(io),
      .sel_even(s_even),
      .sel_odd(s_odd),
      .req_in(sync2_q[15:8]),
      .level_en(level_mode_enable),
      .ack_first(ack_first),
      .ack_second(ack_second & m_casc),
      .int_out(s_int),
      .vector(s_vec),
      .cascade_hit(),
      .rd_data(s_rd)
   );

   assign cpu_int = m_int;

   // Vector register; the slave answers when it owns the grant
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ack_vector <= 8'h00;
         ack_vector_valid <= 1'b0;
      end
      else
      begin
         ack_vector_valid <= ack_second; // RULE22
         if (ack_second)
            ack_vector <= m_casc ? s_vec : m_vec; // RULE27
      end
   end

   // Read data register
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         io_rdata <= 8'h00;
      else if (io.rd)
         io_rdata <= (m_even || m_odd) ? m_rd
                   : (s_even || s_odd) ? s_rd : 8'h00;
   end

   AST_VEC_BASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ack_second && !m_casc |=> ack_vector_valid
      && ack_vector == $past(m_vec)) // RULE27
      else $error("vector not driven on second acknowledge");
endmodule // pic_pair
`default_nettype wire

// file: tb/host_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_cpu_model (
   // Clock
   input wire logic clk_sys,
   // Host cycles toward the controllers
   output var pic_pair_pkg::io_req_t io,
   output logic ack_pulse,
   // Answers from the controllers
   input wire logic [7:0] io_rdata,
   input wire logic [7:0] ack_vector,
   input wire logic ack_vector_valid
);
   // Idle bus at time zero
   initial
   begin
      io = '0;
      ack_pulse = 1'b0;
   end

   // One write cycle; released fields show inverted values, not stale ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      io.addr = a;
      io.wdata = d;
      io.wr = 1'b1;
      @(negedge clk_sys);
      io.wr = 1'b0;
      io.addr = ~a;
      io.wdata = ~d;
   endtask

   // One read cycle; data is registered at the edge that takes the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      io.addr = a;
      io.rd = 1'b1;
      @(negedge clk_sys);
      io.rd = 1'b0;
      io.addr = ~a;
      d = io_rdata;
   endtask

   // Two acknowledge pulses with an idle cycle between them
   task automatic ack(output logic [7:0] v, output logic ok);
      @(negedge clk_sys);
      ack_pulse = 1'b1;
      @(negedge clk_sys);
      ack_pulse = 1'b0;
      @(negedge clk_sys);
      ack_pulse = 1'b1;
      @(negedge clk_sys);
      ack_pulse = 1'b0;
      v = ack_vector;
      ok = ack_vector_valid;
   endtask

   // Full setup sequence with fixed bits written as software must
   task automatic init(input logic [7:0] even, input logic [7:0] w1,
                       input logic [7:0] w2, input logic [7:0] w3,
                       input logic [7:0] w4);
      wr(even, w1 | 8'h10);
      wr(even + 8'h01, w2);
      if (!w1[1])
         wr(even + 8'h01, w3 & 8'h07);
      if (w1[0] && even == 8'h20)
         wr(even + 8'h01, (w4 & 8'h12) | 8'h01);
   endtask
   // Op words carry bits 4-3 as 00 or 01 from every caller
endmodule // host_cpu_model
`default_nettype wire

// file: tb/cascaded_interrupt_controller_pair_tb.sv
`timescale 1ns/10ps
`default_nettype none

module cascaded_interrupt_controller_pair_tb;
   logic clk_sys;
   logic sys_rst;
   pic_pair_pkg::io_req_t io;
   logic [7:0] io_rdata;
   logic [15:0] irq_pin;
   logic level_mode_enable;
   logic cpu_int;
   logic ack_pulse;
   logic [7:0] ack_vector;
   logic ack_vector_valid;
   int miscompares;
   int compares;

   // Controller pair under test
   pic_pair uut (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .io(io),
      .io_rdata(io_rdata),
      .irq_pin(irq_pin),
      .level_mode_enable(level_mode_enable),
      .cpu_int(cpu_int),
      .ack_pulse(ack_pulse),
      .ack_vector(ack_vector),
      .ack_vector_valid(ack_vector_valid)
   );

   // Host processor issuing I/O and acknowledge cycles
   host_cpu_model host (
      .clk_sys(clk_sys),
      .io(io),
      .ack_pulse(ack_pulse),
      .io_rdata(io_rdata),
      .ack_vector(ack_vector),
      .ack_vector_valid(ack_vector_valid)
   );

   // 100 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Compare one value and count it
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error: %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic complete_run();
      $display("Compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Read a port and compare
   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      check(what, d, exp);
   endtask

   // Acknowledge and compare the vector
   task automatic ack_chk(input logic [7:0] exp);
      logic [7:0] v;
      logic ok;
      host.ack(v, ok);
      check("vector_valid", {7'h0, ok}, 8'h01);
      check("vector", v, exp);
   endtask

   // Wait for the interrupt line under a bound
   task automatic wait_int();
      int n;
      n = 0;
      while (cpu_int !== 1'b1 && n < 12)
      begin
         @(negedge clk_sys);
         n++;
      end
      check("cpu_int", {7'h0, cpu_int}, 8'h01);
      if (cpu_int !== 1'b1)
         complete_run();
   endtask

   // Main sequence
   initial
   begin
      miscompares = 0;
      compares = 0;
      sys_rst = 1'b1;
      irq_pin = 16'h0000;
      level_mode_enable = 1'b0;
      repeat (16) @(negedge clk_sys);
      sys_rst = 1'b0;
      // Setup order, mask loads, slave skips fourth word
      host.init(8'h20, 8'h11, 8'h08, 8'h04, 8'h11);
      host.wr(8'h21, 8'hfb);
      rd_chk("master_mask", 8'h21, 8'hfb);
      host.init(8'ha0, 8'h11, 8'h70, 8'h02, 8'h01);
      host.wr(8'ha1, 8'h5a);
      rd_chk("slave_mask", 8'ha1, 8'h5a);
      host.wr(8'h21, 8'h00);
      host.wr(8'ha1, 8'h00);
      $display("Test setup done");
      // Edge request, acknowledge, readback, non-specific end
      irq_pin[5] = 1'b1;
      wait_int();
      host.wr(8'h20, 8'h0a);
      rd_chk("irr", 8'h20, 8'h20);
      ack_chk(8'h0d);
      host.wr(8'h20, 8'h0b);
      rd_chk("isr", 8'h20, 8'h20);
      host.wr(8'h20, 8'h0a);
      rd_chk("irr_after", 8'h20, 8'h00);
      host.wr(8'h20, 8'h20);
      host.wr(8'h20, 8'h0b);
      rd_chk("isr_eoi", 8'h20, 8'h00);
      irq_pin[5] = 1'b0;
      $display("Test single request done");
      // Fixed priority and specific end
      irq_pin[6] = 1'b1;
      irq_pin[3] = 1'b1;
      wait_int();
      ack_chk(8'h0b);
      host.wr(8'h20, 8'h63);
      rd_chk("isr_sp", 8'h20, 8'h00);
      ack_chk(8'h0e);
      host.wr(8'h20, 8'h20);
      irq_pin[6] = 1'b0;
      irq_pin[3] = 1'b0;
      $display("Test priority done");
      // Set priority, rotation commands and in-service inhibit
      host.wr(8'h20, 8'hc4);
      irq_pin[6] = 1'b1;
      irq_pin[3] = 1'b1;
      wait_int();
      ack_chk(8'h0e);
      repeat (4) @(negedge clk_sys);
      check("cpu_int_inhibit", {7'h0, cpu_int}, 8'h00);
      host.wr(8'h20, 8'ha0);
      wait_int();
      ack_chk(8'h0b);
      host.wr(8'h20, 8'h20);
      irq_pin[6] = 1'b0;
      irq_pin[3] = 1'b0;
      irq_pin[5] = 1'b1;
      irq_pin[7] = 1'b1;
      wait_int();
      ack_chk(8'h0f);
      host.wr(8'h20, 8'he7);
      wait_int();
      ack_chk(8'h0d);
      $display("Test rotation done");
      // Special mask lets a lower level through
      host.wr(8'h20, 8'h68);
      irq_pin[6] = 1'b1;
      wait_int();
      ack_chk(8'h0e);
      host.wr(8'h20, 8'h48);
      host.wr(8'h20, 8'h0b);
      rd_chk("isr_smm", 8'h20, 8'h60);
      host.wr(8'h20, 8'h20);
      rd_chk("isr_ns_top", 8'h20, 8'h40);
      host.wr(8'h20, 8'h20);
      irq_pin[5] = 1'b0;
      irq_pin[6] = 1'b0;
      irq_pin[7] = 1'b0;
      $display("Test special mask done");
      // Slave request through master input 2
      irq_pin[12] = 1'b1;
      wait_int();
      ack_chk(8'h74);
      host.wr(8'ha0, 8'h0b);
      rd_chk("slave_isr", 8'ha0, 8'h10);
      irq_pin[9] = 1'b1;
      wait_int();
      ack_chk(8'h71);
      host.wr(8'ha0, 8'h20);
      rd_chk("slave_isr_nest", 8'ha0, 8'h10);
      host.wr(8'ha0, 8'h20);
      host.wr(8'h20, 8'h20);
      rd_chk("slave_isr_eoi", 8'ha0, 8'h00);
      irq_pin[12] = 1'b0;
      irq_pin[9] = 1'b0;
      $display("Test cascade done");
      // Masked request holds the line low
      host.wr(8'h21, 8'h02);
      irq_pin[1] = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("cpu_int_masked", {7'h0, cpu_int}, 8'h00);
      host.wr(8'h21, 8'h00);
      wait_int();
      ack_chk(8'h09);
      host.wr(8'h20, 8'h20);
      irq_pin[1] = 1'b0;
      $display("Test mask done");
      // Restart as single, level, automatic end
      level_mode_enable = 1'b1;
      host.init(8'h20, 8'hfb, 8'h27, 8'h00, 8'h02);
      host.wr(8'h21, 8'h80);
      rd_chk("mask_after_restart", 8'h21, 8'h80);
      irq_pin[4] = 1'b1;
      wait_int();
      ack_chk(8'h24);
      host.wr(8'h20, 8'h0b);
      rd_chk("isr_auto", 8'h20, 8'h00);
      host.wr(8'h20, 8'h0a);
      rd_chk("irr_level", 8'h20, 8'h10);
      irq_pin[4] = 1'b0;
      repeat (6) @(negedge clk_sys);
      rd_chk("irr_level_low", 8'h20, 8'h00);
      $display("Test restart done");
      // Poll returns the highest pending level
      irq_pin[6] = 1'b1;
      wait_int();
      host.wr(8'h20, 8'h0c);
      rd_chk("poll", 8'h20, 8'h86);
      irq_pin[6] = 1'b0;
      $display("Test poll done");
      complete_run();
   end
endmodule // cascaded_interrupt_controller_pair_tb
`default_nettype wire
